// file: pkg/tsfm_pkg.sv
// package for the transfer switch fault monitor
package tsfm_pkg;
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned TICK_CYC = CLK_HZ;
   localparam logic [26:0] TICK_LAST = 27'(TICK_CYC - 1);
   localparam int unsigned SYNC_LIMIT_S = 120;
   localparam logic [7:0] SYNC_LIMIT = 8'(SYNC_LIMIT_S);
   localparam logic [7:0] TMR_RST = 8'h00;
   localparam logic [1:0] POS_NEUTRAL = 2'h0;
   localparam logic [1:0] POS_FIRST = 2'h1;
   localparam logic [1:0] POS_SECOND = 2'h2;
   localparam logic [1:0] APP_UTIL_GEN = 2'h0;
   localparam logic [1:0] APP_UTIL_UTIL = 2'h1;
   localparam logic [1:0] APP_GEN_GEN = 2'h2;
   typedef enum logic [2:0]
   {
      TSFM_IDLE = 3'h0,
      TSFM_OPEN = 3'h1,
      TSFM_CLOSE = 3'h2,
      TSFM_DIRECT = 3'h3,
      TSFM_SYNC = 3'h4
   } tsfm_state_t;
endpackage : tsfm_pkg

// file: design/tsfm_monitor.sv
// transfer switch fault monitor: move timing, latched faults, event outputs
// Operation
// R1: closed transition, separation failed: raise disconnect failure
// R2: disconnect, network faults latch until reset
// R3: sync failure after 120 seconds unmatched
// R4: sync failure event and relay latch
// R5: after sync failure fall back or retry
// R6: utility-genset: second to neutral to first timed
// R7: utility-genset: first to neutral to second timed
// R8: other modes: preferred/backup moves timed
// R9: open transition: open then close delays
// R10: closed transition: direct move time checked
// R11: move timeout latches fault until reset
// R12: high neutral current above threshold
// R13: load shed, retransfer inhibit follow inputs
// R14: motor disconnect: non-automatic, no moves
// R15: not-in-automatic is OR of conditions
// R16: panel lock blocks buttons and setup
// R17: rotation mismatch flags and inhibits transfer
// R18: preferred source change event naming new
// R19: contact open/close failure then lockout
// R20: loss of phase: leave, block transfer
// R21: source limit events follow sensors
// R22: genset-genset: stop first source, flag
// R23: common alarm ORs faults, clears on reset; the code leaves sync failure out of the OR
// R24: lockout cleared only by reset
// R25: timers count one-second tick, config latched
`timescale 1ns/1ps
module tsfm_monitor
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [1:0] i_position,
   input wire logic [1:0] i_app_mode,
   input wire logic i_closed_mode,
   input wire logic i_sync_fallback_open,
   input wire logic i_rotation_check_en,
   input wire logic i_pref_second,
   input wire logic i_move_req,
   input wire logic i_sync_req,
   input wire logic i_sources_matched,
   input wire logic i_paralleled,
   input wire logic i_separate_fail,
   input wire logic [7:0] i_open_delay_s,
   input wire logic [7:0] i_close_delay_s,
   input wire logic [7:0] i_direct_delay_s,
   input wire logic [7:0] i_separate_delay_s,
   input wire logic i_load_monitor_fitted,
   input wire logic [11:0] i_neutral_amps,
   input wire logic [11:0] i_neutral_limit,
   input wire logic i_load_shed,
   input wire logic i_retransfer_inhibit,
   input wire logic i_motor_disconnect,
   input wire logic i_spring_fail,
   input wire logic i_offline,
   input wire logic i_panel_lock,
   input wire logic i_test_btn,
   input wire logic i_override_btn,
   input wire logic i_setup_wr,
   input wire logic i_reset_btn,
   input wire logic i_rotation_mismatch,
   input wire logic [1:0] i_loss_phase,
   input wire logic [1:0] i_freq_fail,
   input wire logic [1:0] i_imbalance_fail,
   input wire logic [1:0] i_over_volt,
   input wire logic [1:0] i_under_volt,
   input wire logic i_first_not_needed,
   input wire logic i_ncm_batt_low,
   input wire logic i_ncm_comm_err,
   input wire logic i_ctrl_batt_low,
   input wire logic i_charger_err,
   output logic o_move_allow,
   output logic o_fail_disconnect,
   output logic o_fail_sync,
   output logic o_go_open_transition,
   output logic o_fail_transfer,
   output logic o_fail_retransfer,
   output logic [1:0] o_fail_open,
   output logic [1:0] o_fail_close,
   output logic o_lockout,
   output logic o_high_neutral,
   output logic o_load_shed,
   output logic o_retransfer_inhibit,
   output logic o_motor_disc,
   output logic o_not_auto,
   output logic o_panel_lock,
   output logic o_test_accept,
   output logic o_override_accept,
   output logic o_setup_accept,
   output logic o_rotation_fail,
   output logic o_transfer_inhibit,
   output logic o_pref_first_evt,
   output logic o_pref_second_evt,
   output logic [1:0] o_loss_phase,
   output logic [1:0] o_leave_source,
   output logic [1:0] o_freq_fail,
   output logic [1:0] o_imbalance_fail,
   output logic [1:0] o_over_volt,
   output logic [1:0] o_under_volt,
   output logic o_first_stop,
   output logic o_first_stopped,
   output logic o_ncm_batt_low,
   output logic o_ncm_comm_err,
   output logic o_common_alarm
);
   typedef struct packed
   {
      tsfm_pkg::tsfm_state_t st;
      logic [26:0] div;
      logic tick;
      logic [7:0] tmr;
      logic [7:0] sep_tmr;
      logic [7:0] lim_open;
      logic [7:0] lim_close;
      logic [7:0] lim_direct;
      logic [7:0] lim_sep;
      logic [1:0] from_pos;
      logic [1:0] to_pos;
      logic to_backup;
      logic ug_mode;
      logic pref_q;
      logic fdisc;
      logic fsync;
      logic fback;
      logic ftx;
      logic frtx;
      logic [1:0] fopen;
      logic [1:0] fclose;
      logic lock;
      logic nbatt;
      logic ncomm;
      logic alarm;
      logic [1:0] pref_evt;
   } tsfm_reg_t;

   tsfm_reg_t cur_ff;
   tsfm_reg_t nxt_cur;
   logic motion_ok;
   logic fault_any;

   // seconds elapsed reached a limit; zero limits still need one tick
   function automatic logic expired(input logic [7:0] t, input logic [7:0] lim);
      expired = (t >= lim);
   endfunction : expired

   function automatic logic [1:0] other_pos(input logic [1:0] p);
      other_pos = (p == tsfm_pkg::POS_FIRST) ? tsfm_pkg::POS_SECOND : tsfm_pkg::POS_FIRST;
   endfunction : other_pos

   always_comb
   begin
      nxt_cur = cur_ff;
      motion_ok = !i_motor_disconnect && !cur_ff.lock; // [R14] [R24]
      // [R25] one-second tick
      nxt_cur.tick = (cur_ff.div == tsfm_pkg::TICK_LAST);
      nxt_cur.div = nxt_cur.tick ? 27'h0000000 : cur_ff.div + 27'h0000001;
      if (cur_ff.tick && cur_ff.tmr != 8'hFF)
      begin
         nxt_cur.tmr = cur_ff.tmr + 8'h01; // [R25]
      end
      unique case (cur_ff.st)
         tsfm_pkg::TSFM_IDLE:
         begin
            nxt_cur.tmr = tsfm_pkg::TMR_RST;
            if (i_sync_req && i_closed_mode && motion_ok)
            begin
               nxt_cur.st = tsfm_pkg::TSFM_SYNC;
            end
            else if (i_move_req && motion_ok && i_position != tsfm_pkg::POS_NEUTRAL)
            begin
               // [R25] limits frozen for the whole attempt
               nxt_cur.lim_open = i_open_delay_s;
               nxt_cur.lim_close = i_close_delay_s;
               nxt_cur.lim_direct = i_direct_delay_s;
               nxt_cur.from_pos = i_position;
               nxt_cur.to_pos = other_pos(i_position);
               nxt_cur.ug_mode = (i_app_mode == tsfm_pkg::APP_UTIL_GEN);
               nxt_cur.to_backup = (i_position == (i_pref_second ?
                  tsfm_pkg::POS_SECOND : tsfm_pkg::POS_FIRST));
               nxt_cur.st = i_closed_mode ? tsfm_pkg::TSFM_DIRECT : tsfm_pkg::TSFM_OPEN;
            end
         end
         tsfm_pkg::TSFM_SYNC:
         begin
            if (i_sources_matched || !i_sync_req)
            begin
               nxt_cur.st = tsfm_pkg::TSFM_IDLE;
            end
            else if (cur_ff.tick && expired(cur_ff.tmr + 8'h01, tsfm_pkg::SYNC_LIMIT))
            begin
               nxt_cur.fsync = 1'b1; // [R3] [R4]
               nxt_cur.fback = i_sync_fallback_open; // [R5]
               nxt_cur.tmr = tsfm_pkg::TMR_RST; // [R5] retry restarts window
               if (i_sync_fallback_open)
               begin
                  nxt_cur.st = tsfm_pkg::TSFM_IDLE;
               end
            end
         end
         tsfm_pkg::TSFM_OPEN:
         begin
            if (i_position == tsfm_pkg::POS_NEUTRAL)
            begin
               nxt_cur.tmr = tsfm_pkg::TMR_RST;
               nxt_cur.st = tsfm_pkg::TSFM_CLOSE; // [R9]
            end
            else if (expired(cur_ff.tmr, cur_ff.lim_open) && cur_ff.tick)
            begin
               nxt_cur.fopen[cur_ff.from_pos[1]] = 1'b1; // [R19] [R9]
               nxt_cur.lock = 1'b1; // [R19] [R24]
               nxt_cur.st = tsfm_pkg::TSFM_IDLE;
            end
         end
         tsfm_pkg::TSFM_CLOSE:
         begin
            if (i_position == cur_ff.to_pos)
            begin
               nxt_cur.st = tsfm_pkg::TSFM_IDLE;
            end
            else if (expired(cur_ff.tmr, cur_ff.lim_close) && cur_ff.tick)
            begin
               nxt_cur.fclose[cur_ff.to_pos[1]] = 1'b1; // [R19] [R9]
               nxt_cur.lock = 1'b1; // [R24]
               nxt_cur.st = tsfm_pkg::TSFM_IDLE;
            end
         end
         tsfm_pkg::TSFM_DIRECT:
         begin
            if (i_position == cur_ff.to_pos)
            begin
               nxt_cur.st = tsfm_pkg::TSFM_IDLE;
            end
            else if (expired(cur_ff.tmr, cur_ff.lim_direct) && cur_ff.tick)
            begin
               nxt_cur.st = tsfm_pkg::TSFM_IDLE; // [R10]
            end
         end
         default:
         begin
            nxt_cur.st = tsfm_pkg::TSFM_IDLE;
         end
      endcase
      // timeout classification for any timed move
      if (cur_ff.st != tsfm_pkg::TSFM_IDLE && cur_ff.st != tsfm_pkg::TSFM_SYNC
          && nxt_cur.st == tsfm_pkg::TSFM_IDLE && i_position != cur_ff.to_pos)
      begin
         if (cur_ff.ug_mode)
         begin
            nxt_cur.ftx = cur_ff.ftx | (cur_ff.from_pos == tsfm_pkg::POS_FIRST); // [R7] [R11]
            nxt_cur.frtx = cur_ff.frtx | (cur_ff.from_pos == tsfm_pkg::POS_SECOND); // [R6] [R11]
         end
         else
         begin
            nxt_cur.ftx = cur_ff.ftx | cur_ff.to_backup; // [R8] [R11]
            nxt_cur.frtx = cur_ff.frtx | !cur_ff.to_backup; // [R8] [R11]
         end
      end
      // separation supervision while paralleled
      if (i_closed_mode && i_paralleled && i_separate_fail)
      begin
         if (cur_ff.sep_tmr == 8'h00)
         begin
            nxt_cur.lim_sep = i_separate_delay_s; // [R25]
         end
         if (cur_ff.tick && cur_ff.sep_tmr != 8'hFF)
         begin
            nxt_cur.sep_tmr = cur_ff.sep_tmr + 8'h01;
         end
         if (cur_ff.sep_tmr != 8'h00 && expired(cur_ff.sep_tmr, cur_ff.lim_sep))
         begin
            nxt_cur.fdisc = 1'b1; // [R1]
         end
      end
      else
      begin
         nxt_cur.sep_tmr = 8'h00;
      end
      nxt_cur.nbatt = cur_ff.nbatt | i_ncm_batt_low; // [R2]
      nxt_cur.ncomm = cur_ff.ncomm | i_ncm_comm_err; // [R2]
      // [R18] one-cycle event on preferred source change
      nxt_cur.pref_q = i_pref_second;
      nxt_cur.pref_evt = 2'b00;
      if (i_app_mode != tsfm_pkg::APP_UTIL_GEN && i_pref_second != cur_ff.pref_q)
      begin
         nxt_cur.pref_evt = i_pref_second ? 2'b10 : 2'b01; // [R18]
      end
      fault_any = i_ctrl_batt_low | i_charger_err | i_spring_fail | nxt_cur.lock
         | nxt_cur.ftx | nxt_cur.frtx | nxt_cur.fdisc | nxt_cur.nbatt | nxt_cur.ncomm
         | (|nxt_cur.fopen) | (|nxt_cur.fclose);
      nxt_cur.alarm = cur_ff.alarm | fault_any; // [R23]
      // reset clears latches; a disconnect or network fault present this cycle wins and sets its latch again
      if (i_reset_btn)
      begin
         nxt_cur.fdisc = i_closed_mode && i_paralleled && i_separate_fail
            && cur_ff.sep_tmr != 8'h00 && expired(cur_ff.sep_tmr, cur_ff.lim_sep); // [R2]
         nxt_cur.nbatt = i_ncm_batt_low; // [R2]
         nxt_cur.ncomm = i_ncm_comm_err; // [R2]
         nxt_cur.fsync = 1'b0; // [R4]
         nxt_cur.fback = 1'b0;
         nxt_cur.ftx = 1'b0; // [R11]
         nxt_cur.frtx = 1'b0; // [R11]
         nxt_cur.fopen = 2'b00;
         nxt_cur.fclose = 2'b00;
         nxt_cur.lock = 1'b0; // [R24]
         nxt_cur.alarm = 1'b0; // [R23] drops for a cycle, then reasserts if faults persist
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         cur_ff <= '0;
      end
      else
      begin
         cur_ff <= nxt_cur;
      end
   end

   // outputs registered so every port is a flip-flop
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         o_move_allow <= 1'b0;
         o_high_neutral <= 1'b0;
         o_load_shed <= 1'b0;
         o_retransfer_inhibit <= 1'b0;
         o_motor_disc <= 1'b0;
         o_not_auto <= 1'b0;
         o_panel_lock <= 1'b0;
         o_test_accept <= 1'b0;
         o_override_accept <= 1'b0;
         o_setup_accept <= 1'b0;
         o_rotation_fail <= 1'b0;
         o_transfer_inhibit <= 1'b0;
         o_loss_phase <= 2'b00;
         o_leave_source <= 2'b00;
         o_freq_fail <= 2'b00;
         o_imbalance_fail <= 2'b00;
         o_over_volt <= 2'b00;
         o_under_volt <= 2'b00;
         o_first_stop <= 1'b0;
         o_first_stopped <= 1'b0;
      end
      else
      begin
         o_move_allow <= !i_motor_disconnect && !nxt_cur.lock; // [R14] [R24]
         o_high_neutral <= i_load_monitor_fitted && (i_neutral_amps > i_neutral_limit); // [R12]
         o_load_shed <= i_load_shed; // [R13]
         o_retransfer_inhibit <= i_retransfer_inhibit; // [R13]
         o_motor_disc <= i_motor_disconnect; // [R14]
         o_not_auto <= i_motor_disconnect | i_spring_fail | i_offline
            | nxt_cur.lock | nxt_cur.fdisc; // [R15]
         o_panel_lock <= i_panel_lock; // [R16]
         o_test_accept <= i_test_btn && !i_panel_lock; // [R16]
         o_override_accept <= i_override_btn && !i_panel_lock; // [R16]
         o_setup_accept <= i_setup_wr && !i_panel_lock; // [R16]
         o_rotation_fail <= i_rotation_check_en && i_rotation_mismatch; // [R17]
         o_transfer_inhibit <= (i_rotation_check_en && i_rotation_mismatch)
            | (|i_loss_phase); // [R17] [R20]
         o_loss_phase <= i_loss_phase; // [R20]
         o_leave_source <= i_loss_phase; // [R20]
         o_freq_fail <= i_freq_fail; // [R21]
         o_imbalance_fail <= i_imbalance_fail; // [R21]
         o_over_volt <= i_over_volt; // [R21]
         o_under_volt <= i_under_volt; // [R21]
         o_first_stop <= (i_app_mode == tsfm_pkg::APP_GEN_GEN) && i_first_not_needed; // [R22]
         o_first_stopped <= (i_app_mode == tsfm_pkg::APP_GEN_GEN) && i_first_not_needed; // [R22]
      end
   end

   assign o_fail_disconnect = cur_ff.fdisc;
   assign o_fail_sync = cur_ff.fsync;
   assign o_go_open_transition = cur_ff.fback;
   assign o_fail_transfer = cur_ff.ftx;
   assign o_fail_retransfer = cur_ff.frtx;
   assign o_fail_open = cur_ff.fopen;
   assign o_fail_close = cur_ff.fclose;
   assign o_lockout = cur_ff.lock;
   assign o_pref_first_evt = cur_ff.pref_evt[0];
   assign o_pref_second_evt = cur_ff.pref_evt[1];
   assign o_ncm_batt_low = cur_ff.nbatt;
   assign o_ncm_comm_err = cur_ff.ncomm;
   assign o_common_alarm = cur_ff.alarm;
endmodule : tsfm_monitor

// file: sim/tsfm_mech_model.sv
// behavioural switch mechanism: walks through neutral to the target source
`timescale 1ns/1ps
module tsfm_mech_model
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_slow,
   input wire logic [1:0] i_target,
   output logic [1:0] o_position
);
   logic [4:0] wait_ff;
   // a step takes 5 cycles, or 25 when slow, so the device sees both paces
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         o_position <= tsfm_pkg::POS_FIRST;
         wait_ff <= 5'h00;
      end
      else if (o_position != i_target && wait_ff < (i_slow ? 5'h18 : 5'h04))
      begin
         wait_ff <= wait_ff + 5'h01;
      end
      else
      begin
         wait_ff <= 5'h00;
         if (o_position != i_target)
         begin
            o_position <= (o_position == tsfm_pkg::POS_NEUTRAL) ? i_target : tsfm_pkg::POS_NEUTRAL;
         end
      end
   end
endmodule : tsfm_mech_model

// file: sim/tsfm_monitor_checker.sv
// concurrent assertions on the fault monitor ports
`timescale 1ns/1ps
module tsfm_monitor_checker
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_load_shed,
   input wire logic i_retransfer_inhibit,
   input wire logic i_motor_disconnect,
   input wire logic i_spring_fail,
   input wire logic i_offline,
   input wire logic i_panel_lock,
   input wire logic i_reset_btn,
   input wire logic i_load_monitor_fitted,
   input wire logic [11:0] i_neutral_amps,
   input wire logic [11:0] i_neutral_limit,
   input wire logic [1:0] i_over_volt,
   input wire logic [1:0] i_loss_phase,
   input wire logic o_load_shed,
   input wire logic o_retransfer_inhibit,
   input wire logic o_motor_disc,
   input wire logic o_not_auto,
   input wire logic o_move_allow,
   input wire logic o_panel_lock,
   input wire logic o_test_accept,
   input wire logic o_override_accept,
   input wire logic o_setup_accept,
   input wire logic o_ncm_batt_low,
   input wire logic [1:0] o_over_volt,
   input wire logic o_high_neutral,
   input wire logic o_transfer_inhibit,
   input wire logic [1:0] o_loss_phase,
   input wire logic o_fail_transfer,
   input wire logic o_fail_retransfer,
   input wire logic o_fail_sync,
   input wire logic o_lockout,
   input wire logic o_common_alarm
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);
   a_shed_follows: assert property (!$past(i_rst) |-> o_load_shed == $past(i_load_shed)
      && o_retransfer_inhibit == $past(i_retransfer_inhibit)) else $error("event copy wrong");
   a_motor_holds: assert property (!$past(i_rst) && $past(i_motor_disconnect)
      |-> o_motor_disc && o_not_auto && !o_move_allow) else $error("motor disconnect ignored");
   a_not_auto_or: assert property ($past(i_spring_fail || i_offline) && !$past(i_rst)
      |-> o_not_auto) else $error("not-auto missing");
   a_lock_blocks: assert property (!$past(i_rst) && $past(i_panel_lock) |-> o_panel_lock
      && !(o_test_accept || o_override_accept || o_setup_accept)) else $error("lock leaked");
   a_ncm_holds: assert property (o_ncm_batt_low && !i_reset_btn |=> o_ncm_batt_low)
      else $error("latch dropped");
   a_limits_follow: assert property (!$past(i_rst) |-> o_over_volt == $past(i_over_volt))
      else $error("limit event wrong");
   a_neutral_high: assert property (!$past(i_rst) |-> o_high_neutral
      == $past(i_load_monitor_fitted && (i_neutral_amps > i_neutral_limit))) else $error("neutral");
   a_phase_inhibit: assert property (!$past(i_rst) && $past(|i_loss_phase)
      |-> o_transfer_inhibit && o_loss_phase == $past(i_loss_phase)) else $error("phase loss");
   a_faults_latch: assert property ((o_fail_transfer || o_fail_retransfer) && !i_reset_btn
      |=> o_fail_transfer || o_fail_retransfer) else $error("move fault dropped");
   a_lockout_holds: assert property (o_lockout && !i_reset_btn |=> o_lockout)
      else $error("lockout dropped");
   a_sync_holds: assert property (o_fail_sync && !i_reset_btn |=> o_fail_sync)
      else $error("sync fault dropped");
   a_alarm_holds: assert property (o_common_alarm && !i_reset_btn |=> o_common_alarm)
      else $error("alarm dropped");
   c_latched: cover property (o_ncm_batt_low && !i_reset_btn ##1 o_ncm_batt_low);
   c_motor: cover property (i_motor_disconnect ##1 o_motor_disc);
   c_lock: cover property (i_panel_lock ##1 o_panel_lock);
endmodule : tsfm_monitor_checker

bind tsfm_monitor tsfm_monitor_checker u_chk (.*);

// file: sim/tb_top.sv
// self-checking random bench for the transfer switch fault monitor
`timescale 1ns/1ps
module tb_top;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic [1:0] i_position, i_app_mode, i_loss_phase, i_freq_fail, i_imbalance_fail, tgt;
   logic [1:0] i_over_volt, i_under_volt, o_fail_open, o_fail_close, o_loss_phase;
   logic [1:0] o_leave_source, o_freq_fail, o_imbalance_fail, o_over_volt, o_under_volt;
   logic i_closed_mode, i_sync_fallback_open, i_rotation_check_en, i_pref_second, i_move_req;
   logic i_sync_req, i_sources_matched, i_paralleled, i_separate_fail, i_load_monitor_fitted;
   logic i_load_shed, i_retransfer_inhibit, i_motor_disconnect, i_spring_fail, i_offline;
   logic i_panel_lock, i_test_btn, i_override_btn, i_setup_wr, i_reset_btn, i_rotation_mismatch;
   logic i_first_not_needed, i_ncm_batt_low, i_ncm_comm_err, i_ctrl_batt_low, i_charger_err;
   logic [7:0] i_open_delay_s, i_close_delay_s, i_direct_delay_s, i_separate_delay_s;
   logic [11:0] i_neutral_amps, i_neutral_limit;
   logic o_move_allow, o_fail_disconnect, o_fail_sync, o_go_open_transition, o_fail_transfer;
   logic o_fail_retransfer, o_lockout, o_high_neutral, o_load_shed, o_retransfer_inhibit;
   logic o_motor_disc, o_not_auto, o_panel_lock, o_test_accept, o_override_accept;
   logic o_setup_accept, o_rotation_fail, o_transfer_inhibit, o_pref_first_evt, o_pref_second_evt;
   logic o_first_stop, o_first_stopped, o_ncm_batt_low, o_ncm_comm_err, o_common_alarm, slow;
   logic p_pref, e_bat, e_com, e_alm;
   int error_cnt = 0;
   int comparisons = 0;
   logic [31:0] r;
   always #4 i_clk_sys = ~i_clk_sys;
   tsfm_monitor u_dut (.*);
   tsfm_mech_model u_mech (.i_clk_sys, .i_rst, .i_slow(slow), .i_target(tgt), .o_position(i_position));
   task automatic summarize();
      if (error_cnt == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   function automatic logic [1:0] pref_evt(logic [1:0] mode, logic was, logic now);
      // event bits {first, second}; silent in utility-to-genset
      return (mode == tsfm_pkg::APP_UTIL_GEN) ? 2'h0 : {was & ~now, ~was & now};
   endfunction : pref_evt
   task automatic drive();
      r = $urandom;
      {i_load_shed, i_retransfer_inhibit, i_spring_fail, i_offline, i_panel_lock} = r[4:0];
      {i_test_btn, i_override_btn, i_setup_wr, i_rotation_mismatch, i_rotation_check_en} = r[9:5];
      {i_loss_phase, i_freq_fail, i_imbalance_fail, i_over_volt, i_under_volt} = r[19:10];
      {i_pref_second, i_first_not_needed, i_load_monitor_fitted, i_closed_mode, slow} = r[24:20];
      i_motor_disconnect = (r[27:25] == 3'h0);
      i_ncm_batt_low = (r[31:28] == 4'h0);
      r = $urandom;
      i_ncm_comm_err = (r[3:0] == 4'h1);
      i_reset_btn = (r[7:4] == 4'h2);
      {i_sync_req, i_sources_matched, i_paralleled, i_separate_fail, i_move_req} = r[12:8];
      {i_sync_fallback_open, i_ctrl_batt_low, i_charger_err} = r[15:13];
      i_app_mode = 2'(r[17:16] % 3);
      tgt = 2'(r[19:18] % 3);
      i_neutral_amps = 12'($urandom);
      // equal values probe the strict threshold
      i_neutral_limit = r[20] ? i_neutral_amps : 12'($urandom);
      {i_open_delay_s, i_close_delay_s, i_direct_delay_s, i_separate_delay_s} = $urandom | 32'h01010101;
   endtask : drive
   // timed faults need whole one-second ticks, out of reach here, so lockout stays clear
   task automatic step();
      e_bat = i_ncm_batt_low | (e_bat & ~i_reset_btn);
      e_com = i_ncm_comm_err | (e_com & ~i_reset_btn);
      // reset press drops the alarm for one cycle even if faults persist
      e_alm = ~i_reset_btn & (e_alm | i_ctrl_batt_low | i_charger_err | i_spring_fail | e_bat | e_com);
      chk(o_common_alarm, e_alm, "alarm");
      // no one-second tick is reached in this run, so timed faults must stay clear
      chk({o_fail_disconnect, o_fail_sync, o_go_open_transition, o_fail_transfer, o_lockout}, 5'h00, "timed");
      chk({o_fail_retransfer, o_fail_open, o_fail_close, o_leave_source}, {5'h00, i_loss_phase}, "leave");
      chk({o_load_shed, o_retransfer_inhibit}, {i_load_shed, i_retransfer_inhibit}, "follow");
      chk({o_motor_disc, o_move_allow}, {i_motor_disconnect, ~i_motor_disconnect}, "motor");
      chk(o_not_auto, i_motor_disconnect | i_spring_fail | i_offline, "not auto");
      chk({o_panel_lock, o_test_accept, o_override_accept, o_setup_accept},
         {i_panel_lock, {i_test_btn, i_override_btn, i_setup_wr} & {3{~i_panel_lock}}}, "lock");
      chk({o_ncm_batt_low, o_ncm_comm_err}, {e_bat, e_com}, "ncm latch");
      chk({o_freq_fail, o_imbalance_fail, o_over_volt, o_under_volt},
         {i_freq_fail, i_imbalance_fail, i_over_volt, i_under_volt}, "limits");
      chk(o_high_neutral, i_load_monitor_fitted & (i_neutral_amps > i_neutral_limit), "neutral");
      chk(o_rotation_fail, i_rotation_mismatch & i_rotation_check_en, "rotation");
      chk({o_transfer_inhibit, o_loss_phase},
         {(i_rotation_mismatch & i_rotation_check_en) | (|i_loss_phase), i_loss_phase}, "phase");
      chk({o_pref_first_evt, o_pref_second_evt}, pref_evt(i_app_mode, p_pref, i_pref_second), "pref");
      chk({o_first_stop, o_first_stopped},
         {2{i_first_not_needed & (i_app_mode == tsfm_pkg::APP_GEN_GEN)}}, "first stop");
      p_pref = i_pref_second;
   endtask : step
   initial
   begin
      #30000;
      error_cnt++;
      summarize();
   end
   initial
   begin
      void'($urandom(32'h12DF));
      drive();
      repeat (5) @(negedge i_clk_sys);
      {e_bat, e_com, p_pref, e_alm} = 4'h0;
      for (int k = 0; k < 3000; k++)
      begin
         i_rst = (k >= 1500 && k < 1503);
         @(negedge i_clk_sys);
         if (i_rst)
         begin
            chk({o_not_auto, o_ncm_batt_low, o_load_shed, o_over_volt}, 16'h0000, "reset");
            {e_bat, e_com, p_pref, e_alm} = 4'h0;
         end
         else
         begin
            step();
            drive();
         end
      end
      summarize();
   end
endmodule : tb_top
